/* include/exec_pkg.sv */
package exec_pkg;

  // Widths
  localparam int unsigned IW    = 14;
  localparam int unsigned PC_W  = 15;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned AXI_AW = 8;

  // Register byte addresses on the bus
  localparam logic [AXI_AW-1:0] ADDR_ACC    = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_UPPER  = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_PTR0   = 8'h0C;
  localparam logic [AXI_AW-1:0] ADDR_PTR1   = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_OPTION = 8'h14;
  localparam logic [AXI_AW-1:0] ADDR_DIR    = 8'h18;
  localparam logic [AXI_AW-1:0] ADDR_CTRL   = 8'h1C;

  // Control word bit positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_GEN_BIT = 7;
  localparam int unsigned CTRL_SRF_BIT = 8;
  localparam int unsigned CTRL_SLP_BIT = 9;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [7:0]       ACC_RST    = 8'h00;
  localparam logic [4:0]       STATUS_RST = 5'h18;
  localparam logic [6:0]       UPPER_RST  = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RST    = 16'h0000;
  localparam logic [7:0]       OPTION_RST = 8'hFF;
  localparam logic [7:0]       DIR_RST    = 8'hFF;

  // Pointer-update codes and operand constants
  localparam logic [1:0] UPD_PRE_INC  = 2'h0;
  localparam logic [1:0] UPD_PRE_DEC  = 2'h1;
  localparam logic [1:0] UPD_POST_INC = 2'h2;
  localparam logic [1:0] UPD_POST_DEC = 2'h3;
  localparam logic [3:0] DIR_A_SEL   = 4'h5;
  localparam logic [3:0] DIR_B_SEL   = 4'h6;
  localparam logic [3:0] DIR_C_SEL   = 4'h7;
  localparam logic [6:0] WIN0_ADDR   = 7'h00;
  localparam logic [6:0] WIN1_ADDR   = 7'h01;

  // Instruction encodings, most specific first
  localparam logic [IW-1:0] OPC_NOP    = 14'h0000;
  localparam logic [IW-1:0] OPC_RESET  = 14'h0001;
  localparam logic [IW-1:0] OPC_RETURN = 14'h0008;
  localparam logic [IW-1:0] OPC_IRET   = 14'h0009;
  localparam logic [IW-1:0] OPC_OPTION = 14'h0062;
  localparam logic [IW-1:0] OPC_SLEEP  = 14'h0063;
  localparam logic [IW-1:0] OPC_DIRW   = 14'h006?;
  localparam logic [IW-1:0] OPC_STIND  = 14'h001?;
  localparam logic [IW-1:0] OPC_STACC  = 14'h01??;
  localparam logic [IW-1:0] OPC_SUBRA  = 14'h02??;
  localparam logic [IW-1:0] OPC_XORRA  = 14'h06??;
  localparam logic [IW-1:0] OPC_RRC    = 14'h0C??;
  localparam logic [IW-1:0] OPC_RLC    = 14'h0D??;
  localparam logic [IW-1:0] OPC_SWAP   = 14'h0E??;
  localparam logic [IW-1:0] OPC_LDLIT  = 14'h30??;
  localparam logic [IW-1:0] OPC_LDPAG  = 14'h31??;
  localparam logic [IW-1:0] OPC_RETLIT = 14'h34??;
  localparam logic [IW-1:0] OPC_XORLA  = 14'h3A??;
  localparam logic [IW-1:0] OPC_SUBRAB = 14'h3B??;
  localparam logic [IW-1:0] OPC_SUBLA  = 14'h3C??;
  localparam logic [IW-1:0] OPC_STOFF  = 14'h3F??;

  // Decoded operations
  typedef enum logic [4:0] {
    OP_NOP, OP_RESET, OP_RETURN, OP_IRET, OP_OPTION, OP_SLEEP, OP_DIRW,
    OP_STIND, OP_STOFF, OP_STACC, OP_SUBRA, OP_SUBRAB, OP_SUBLA, OP_XORRA,
    OP_XORLA, OP_RRC, OP_RLC, OP_SWAP, OP_LDLIT, OP_LDPAG, OP_RETLIT
  } op_t;

  // Status flags, active-low ones marked _n
  typedef struct packed {
    logic wdt_n;
    logic slp_n;
    logic z;
    logic hc;
    logic c;
  } status_t;

  // File register write request
  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [7:0]       wdata;
    logic             we;
  } file_req_t;

endpackage : exec_pkg

/* rtl/instr_exec.sv */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// (RQ1) Page literal loads upper latch, flags kept
// (RQ2) Literal loads accumulator, flags kept
// (RQ3) Store accumulator to file register, one cycle
// (RQ4) Pointer code selects pre/post increment/decrement
// (RQ5) Offset store uses pointer plus offset, pointer kept
// (RQ6) Pointers are 16 bits and wrap
// (RQ7) Indirect store and pointer steps keep flags
// (RQ8) Window addresses go through the pointer
// (RQ9) Option load copies accumulator, flags kept
// (RQ10) Software reset resets, clears reset flag
// (RQ11) Interrupt return pops, sets enable, two cycles
// (RQ12) Subroutine return pops into counter, two cycles
// (RQ13) Literal return loads accumulator and counter
// (RQ14) Rotate left through carry, destination bit
// (RQ15) Rotate right through carry, destination bit
// (RQ16) Literal minus accumulator sets carry, digit, zero
// (RQ17) Register minus accumulator sets carry, digit, zero
// (RQ18) Borrow subtract also takes inverted carry
// (RQ19) Sleep clears watchdog, sets flags, halts
// (RQ20) Nibble exchange swaps halves, no flags
// (RQ21) Exclusive OR updates only zero flag
// (RQ22) Direction load takes 5..7 only
// (RQ23) Other instructions take one cycle
module instr_exec
  import exec_pkg::*;
(
  input  logic              clk_i,
  input  logic              rst_n_i,
  input  logic              instr_valid_i,
  input  logic [IW-1:0]     instr_i,
  output logic              instr_ready_o,
  output file_req_t         file_req_o,
  input  logic [7:0]        file_rdata_i,
  input  logic [PC_W-1:0]   stack_top_i,
  output logic              stack_pop_o,
  output logic              pc_load_o,
  output logic [PC_W-1:0]   pc_o,
  output logic [6:0]        program_counter_upper_latch_o,
  output logic [7:0]        option_o,
  output logic [7:0]        port_a_direction_o,
  output logic [7:0]        port_b_direction_o,
  output logic [7:0]        port_c_direction_o,
  output logic              global_interrupt_enable_o,
  output logic              sw_reset_o,
  output logic              wdt_clear_o,
  output logic              sleeping_o,
  input  logic              wake_i,
  input  logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  logic              s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  logic [31:0]       s_axi_wdata_i,
  input  logic [3:0]        s_axi_wstrb_i,
  input  logic              s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  logic              s_axi_bready_i,
  input  logic [AXI_AW-1:0] s_axi_araddr_i,
  input  logic              s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  logic              s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND, ST_SLEEP} state_t;

  state_t                 state_q;   // Sequencer
  op_t                    op_q;      // Latched operation
  logic [IW-1:0]          instr_q;   // Latched word
  logic [7:0]             acc_q;     // Accumulator
  status_t                st_q;      // Flags
  logic [6:0]             upper_q;   // Upper latch
  logic [1:0][PTR_W-1:0]  ptr_q;     // Indirect pointers
  logic [7:0]             opt_q;     // Option register
  logic [2:0][7:0]        dir_q;     // Port C..A directions
  logic                   run_q;     // Execution enable
  logic                   gen_q;     // Global enable
  logic                   srf_n_q;   // Reset-instruction flag
  file_req_t              freq_q;    // File write request
  logic                   pop_q;     // Stack pop pulse
  logic                   swrst_q;   // Soft reset pulse
  logic                   wdtclr_q;  // Watchdog clear pulse
  logic [PC_W-1:0]        pc_q;      // Popped counter
  logic                   aw_q, w_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0]      awaddr_q;
  logic [31:0]            wdata_q, rdata_q;
  logic [3:0]             wstrb_q;
  logic [1:0]             bresp_q, rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode by priority match
  function automatic op_t decode(input logic [IW-1:0] w);
    casez (w)
      OPC_NOP:    return OP_NOP;
      OPC_RESET:  return OP_RESET;
      OPC_RETURN: return OP_RETURN;
      OPC_IRET:   return OP_IRET;
      OPC_OPTION: return OP_OPTION;
      OPC_SLEEP:  return OP_SLEEP;
      // (RQ22) Out-of-range operand is no operation
      OPC_DIRW:   return (w[3:0] >= DIR_A_SEL && w[3:0] <= DIR_C_SEL) ? OP_DIRW : OP_NOP;
      OPC_STIND:  return OP_STIND;
      OPC_STACC:  return OP_STACC;
      OPC_SUBRA:  return OP_SUBRA;
      OPC_XORRA:  return OP_XORRA;
      OPC_RRC:    return OP_RRC;
      OPC_RLC:    return OP_RLC;
      OPC_SWAP:   return OP_SWAP;
      OPC_LDLIT:  return OP_LDLIT;
      OPC_LDPAG:  return OP_LDPAG;
      OPC_RETLIT: return OP_RETLIT;
      OPC_XORLA:  return OP_XORLA;
      OPC_SUBRAB: return OP_SUBRAB;
      OPC_SUBLA:  return OP_SUBLA;
      OPC_STOFF:  return OP_STOFF;
      default:    return OP_NOP;
    endcase
  endfunction : decode

  // Pointer step; 16-bit sum wraps naturally
  function automatic logic [PTR_W-1:0] step16(input logic [PTR_W-1:0] p, input logic dec);
    return dec ? p - 16'h0001 : p + 16'h0001;
  endfunction : step16

  // a - b - !cin, returns {carry, digit carry, result}
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                     input logic cin);
    logic [8:0] t;
    logic [4:0] n;
    t = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {t[8], n[4], t[7:0]};
  endfunction : sub8

  // Bus address decode
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a inside {ADDR_ACC, ADDR_STATUS, ADDR_UPPER, ADDR_PTR0, ADDR_PTR1,
                     ADDR_OPTION, ADDR_DIR, ADDR_CTRL};
  endfunction : mapped

  // Register read view, zero when unmapped
  function automatic logic [31:0] read_word(input logic [AXI_AW-1:0] a);
    case (a)
      ADDR_ACC:    return {24'h000000, acc_q};
      ADDR_STATUS: return {27'h0000000, st_q};
      ADDR_UPPER:  return {25'h0000000, upper_q};
      ADDR_PTR0:   return {16'h0000, ptr_q[0]};
      ADDR_PTR1:   return {16'h0000, ptr_q[1]};
      ADDR_OPTION: return {24'h000000, opt_q};
      ADDR_DIR:    return {8'h00, dir_q};
      ADDR_CTRL:   return {22'h000000, (state_q == ST_SLEEP), srf_n_q, gen_q,
                           6'h00, run_q};
      default:     return 32'h00000000;
    endcase
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and selection
  wire ex       = (state_q == ST_EXEC);
  wire wr_go    = aw_q & w_q & ~bvalid_q & (state_q != ST_EXEC);
  wire take     = instr_valid_i & instr_ready_o;
  wire soft_clr = ~rst_n_i | swrst_q;
  wire is_ret   = op_q inside {OP_RETURN, OP_IRET, OP_RETLIT};
  wire dest_f   = instr_q[7];
  wire [7:0] lit  = instr_q[7:0];
  wire [7:0] rd   = file_rdata_i;
  wire       n_i  = instr_i[2];
  wire       nk_i = instr_i[6];
  wire [6:0] f_i  = instr_i[6:0];
  wire [1:0] upd_i = instr_i[1:0];
  wire op_t  op_d = decode(instr_i);
  wire [31:0] wm_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wm  = (read_word(awaddr_q) & ~wm_mask) | (wdata_q & wm_mask);

  // Soft reset cycle refuses a word that the reset would drop
  assign instr_ready_o = (state_q == ST_IDLE) & run_q & ~wr_go & ~swrst_q;

  // Effective file address at accept
  logic [PTR_W-1:0] addr_d;
  always_comb
  begin
    case (op_d)
      // (RQ4) Pre forms step first, post forms use pointer
      OP_STIND:  addr_d = upd_i[1] ? ptr_q[n_i] : step16(ptr_q[n_i], upd_i[0]);
      // (RQ5) Signed offset from pointer
      OP_STOFF:  addr_d = ptr_q[nk_i] + {{10{instr_i[5]}}, instr_i[5:0]};
      // (RQ8) Window maps onto its pointer
      default:   addr_d = (f_i == WIN0_ADDR) ? ptr_q[0] :
                          (f_i == WIN1_ADDR) ? ptr_q[1] : {9'h000, f_i};
    endcase
  end

  // Result, flags and destination
  logic [7:0] res;
  status_t    st_n;
  logic       to_acc, to_file;
  logic [9:0] sb;
  always_comb
  begin
    res     = acc_q;
    st_n    = st_q;
    to_acc  = 1'b0;
    to_file = 1'b0;
    sb      = 10'h000;
    case (op_q)
      // (RQ14) Carry in at bit 0, bit 7 out
      OP_RLC:    begin res = {rd[6:0], st_q.c}; st_n.c = rd[7]; end
      // (RQ15) Carry in at bit 7, bit 0 out
      OP_RRC:    begin res = {st_q.c, rd[7:1]}; st_n.c = rd[0]; end
      // (RQ20) Halves exchanged
      OP_SWAP:   res = {rd[3:0], rd[7:4]};
      // (RQ21) Zero flag only
      OP_XORRA:  begin res = rd ^ acc_q; st_n.z = (res == 8'h00); end
      OP_XORLA:  begin res = lit ^ acc_q; st_n.z = (res == 8'h00); end
      // (RQ17) Register minus accumulator
      OP_SUBRA:  sb = sub8(rd, acc_q, 1'b1);
      // (RQ18) Borrow is inverted carry
      OP_SUBRAB: sb = sub8(rd, acc_q, st_q.c);
      // (RQ16) Literal minus accumulator
      OP_SUBLA:  sb = sub8(lit, acc_q, 1'b1);
      // (RQ2) Literal into accumulator
      OP_LDLIT:  res = lit;
      // (RQ13) Literal into accumulator
      OP_RETLIT: res = lit;
      // (RQ19) Watchdog flags on sleep entry
      OP_SLEEP:  begin st_n.wdt_n = 1'b1; st_n.slp_n = 1'b0; end
      default:   res = acc_q;
    endcase
    if (op_q inside {OP_SUBRA, OP_SUBRAB, OP_SUBLA})
    begin
      res    = sb[7:0];
      st_n.c = sb[9];
      st_n.hc = sb[8];
      st_n.z = (sb[7:0] == 8'h00);
    end
    if (op_q inside {OP_RLC, OP_RRC, OP_SWAP, OP_XORRA, OP_SUBRA, OP_SUBRAB})
    begin
      to_acc  = ~dest_f;
      to_file = dest_f;
    end
    if (op_q inside {OP_XORLA, OP_SUBLA, OP_LDLIT, OP_RETLIT})
      to_acc = 1'b1;
    // (RQ3) Accumulator to file, flags kept
    if (op_q inside {OP_STACC, OP_STIND, OP_STOFF})
      to_file = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (soft_clr)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:   if (take) state_q <= ST_EXEC;
        // (RQ12) Returns hold a second cycle
        ST_EXEC:   state_q <= is_ret ? ST_SECOND :
                              (op_q == OP_SLEEP) ? ST_SLEEP : ST_IDLE;
        ST_SECOND: state_q <= ST_IDLE;
        ST_SLEEP:  if (wake_i) state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
  end

  // Latch instruction at accept
  always_ff @(posedge clk_i)
  begin
    if (soft_clr)
    begin
      op_q    <= OP_NOP;
      instr_q <= OPC_NOP;
    end
    else if (take)
    begin
      op_q    <= op_d;
      instr_q <= instr_i;
    end
  end

  // Architectural state; bus writes never meet an execute cycle
  always_ff @(posedge clk_i)
  begin
    if (soft_clr)
    begin
      acc_q   <= ACC_RST;
      st_q    <= STATUS_RST;
      upper_q <= UPPER_RST;
      ptr_q   <= {PTR_RST, PTR_RST};
      opt_q   <= OPTION_RST;
      dir_q   <= {DIR_RST, DIR_RST, DIR_RST};
      run_q   <= 1'b1;
      gen_q   <= 1'b0;
    end
    else if (wr_go)
      case (awaddr_q)
        ADDR_ACC:    acc_q    <= wm[7:0];
        ADDR_STATUS: st_q     <= wm[4:0];
        ADDR_UPPER:  upper_q  <= wm[6:0];
        ADDR_PTR0:   ptr_q[0] <= wm[15:0];
        ADDR_PTR1:   ptr_q[1] <= wm[15:0];
        ADDR_OPTION: opt_q    <= wm[7:0];
        ADDR_DIR:    dir_q    <= wm[23:0];
        ADDR_CTRL:
        begin
          run_q <= wm[CTRL_RUN_BIT];
          gen_q <= wm[CTRL_GEN_BIT];
        end
        default:     run_q    <= run_q;
      endcase
    else if (ex)
    begin
      // (RQ7) Store forms leave flags as they were
      st_q <= st_n;
      if (to_acc)
        acc_q <= res;
      // (RQ1) Page literal
      if (op_q == OP_LDPAG)
        upper_q <= instr_q[6:0];
      // (RQ9) Option load
      if (op_q == OP_OPTION)
        opt_q <= acc_q;
      // (RQ22) Port select 5, 6, 7
      if (op_q == OP_DIRW)
        dir_q[2'(instr_q[3:0] - DIR_A_SEL)] <= acc_q;
      // (RQ6) Pointer step wraps at 16 bits
      if (op_q == OP_STIND)
        ptr_q[instr_q[2]] <= step16(ptr_q[instr_q[2]], instr_q[0]);
      // (RQ11) Enable set on interrupt return
      if (op_q == OP_IRET)
        gen_q <= 1'b1;
    end
  end

  // (RQ10) Flag survives the soft reset it reports
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      srf_n_q <= 1'b1;
    else if (ex && op_q == OP_RESET)
      srf_n_q <= 1'b0;
    else if (wr_go && awaddr_q == ADDR_CTRL)
      srf_n_q <= wm[CTRL_SRF_BIT];
  end

  // Registered side outputs and pulses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      freq_q   <= '0;
      pop_q    <= 1'b0;
      pc_q     <= '0;
      swrst_q  <= 1'b0;
      wdtclr_q <= 1'b0;
    end
    else
    begin
      if (take)
        freq_q.addr <= addr_d;
      freq_q.we    <= ex & to_file;
      freq_q.wdata <= res;
      // (RQ13) Counter from stack top
      pop_q <= ex & is_ret;
      if (ex && is_ret)
        pc_q <= stack_top_i;
      swrst_q  <= ex & (op_q == OP_RESET);
      // (RQ19) Watchdog and prescaler clear
      wdtclr_q <= ex & (op_q == OP_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {aw_q, w_q, bvalid_q, rvalid_q} <= 4'h0;
      {awaddr_q, wdata_q, wstrb_q}    <= '0;
      {bresp_q, rresp_q, rdata_q}     <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
        {aw_q, awaddr_q} <= {1'b1, s_axi_awaddr_i};
      if (s_axi_wvalid_i && s_axi_wready_o)
        {w_q, wdata_q, wstrb_q} <= {1'b1, s_axi_wdata_i, s_axi_wstrb_i};
      if (wr_go)
      begin
        {aw_q, w_q, bvalid_q} <= 3'h1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= read_word(s_axi_araddr_i);
        rresp_q  <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready_i)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready_o = ~aw_q;
  assign s_axi_wready_o  = ~w_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  assign file_req_o  = freq_q;
  assign stack_pop_o = pop_q;
  assign pc_load_o   = pop_q;
  assign pc_o        = pc_q;
  assign program_counter_upper_latch_o = upper_q;
  assign option_o           = opt_q;
  assign port_a_direction_o = dir_q[0];
  assign port_b_direction_o = dir_q[1];
  assign port_c_direction_o = dir_q[2];
  assign global_interrupt_enable_o = gen_q;
  assign sw_reset_o  = swrst_q;
  assign wdt_clear_o = wdtclr_q;
  assign sleeping_o  = (state_q == ST_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_page; ex && op_q == OP_LDPAG |=> upper_q == $past(instr_q[6:0]) && $stable(st_q);
  endproperty
  a_page: assert property (p_page) // RQ1
    else $error("page literal not loaded");
  property p_lit; ex && op_q == OP_LDLIT |=> acc_q == $past(lit) && $stable(st_q); endproperty
  a_lit: assert property (p_lit) // RQ2
    else $error("literal not loaded");
  property p_store; ex && op_q == OP_STACC |=> file_req_o.we && file_req_o.wdata == $past(acc_q);
  endproperty
  a_store: assert property (p_store) // RQ3
    else $error("store missing");
  property p_offs; ex && op_q == OP_STOFF |=> $stable(ptr_q); endproperty
  a_offs: assert property (p_offs) // RQ5
    else $error("offset store moved pointer");
  property p_ret; ex && op_q == OP_RETURN |=> pc_load_o && pc_o == $past(stack_top_i)
    ##1 state_q == ST_IDLE; endproperty
  a_ret: assert property (p_ret) // RQ12
    else $error("return sequence wrong");
  property p_rfi; ex && op_q == OP_IRET |=> gen_q && stack_pop_o; endproperty
  a_rfi: assert property (p_rfi) // RQ11
    else $error("interrupt return wrong");
  property p_sub; ex && op_q == OP_SUBLA |=> st_q.c == ($past(acc_q) <= $past(lit)); endproperty
  a_sub: assert property (p_sub) // RQ16
    else $error("subtract carry wrong");
  property p_sleep; ex && op_q == OP_SLEEP |=> wdt_clear_o && st_q.wdt_n && !st_q.slp_n
    && sleeping_o; endproperty
  a_sleep: assert property (p_sleep) // RQ19
    else $error("sleep entry wrong");
  property p_rst; ex && op_q == OP_RESET |=> sw_reset_o && !srf_n_q ##1 state_q == ST_IDLE;
  endproperty
  a_rst: assert property (p_rst) // RQ10
    else $error("soft reset wrong");
  property p_one; ex && !is_ret && op_q != OP_SLEEP |=> state_q == ST_IDLE; endproperty
  a_one: assert property (p_one) // RQ23
    else $error("single cycle overrun");

  c_ret: cover property (ex && op_q == OP_RETLIT);
  c_ind: cover property (ex && op_q == OP_STIND ##1 file_req_o.we);
  c_bus: cover property (wr_go ##1 s_axi_bvalid_o);

endmodule : instr_exec

/* tb/tb.sv */
`timescale 1ns/100ps
module tb
  import exec_pkg::*;
;
  logic              clk_i, rst_n_i, instr_valid_i, wake_i, instr_ready_o;
  logic              stack_pop_o, pc_load_o, global_interrupt_enable_o;
  logic              sw_reset_o, wdt_clear_o, sleeping_o;
  logic [IW-1:0]     instr_i;
  file_req_t         file_req_o;
  logic [7:0]        file_rdata_i, option_o, a, r, k;
  logic [7:0]        port_a_direction_o, port_b_direction_o, port_c_direction_o;
  logic [6:0]        program_counter_upper_latch_o;
  logic [PC_W-1:0]   stack_top_i, pc_o, t;
  logic [AXI_AW-1:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic              s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic              s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic              s_axi_rvalid_o, s_axi_rready_i;
  logic [31:0]       s_axi_wdata_i, s_axi_rdata_o, dir;
  logic [3:0]        s_axi_wstrb_i;
  logic [1:0]        s_axi_bresp_o, s_axi_rresp_o, uc;
  logic [4:0]        st;       // Expected status
  logic [15:0]       p, s;     // Expected pointer and step
  logic [33:0]       rq[$], fq[$], pq[$];  // Notes of read, file write, pop
  int                err_count, check_count;

  instr_exec DUT (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #100000;
    err_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task cmp(input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp
  task results();
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // Drivers: bus read, bus write, instruction
  task rd(input logic [7:0] ad, input logic [1:0] rs, input logic [31:0] d);
    rq.push_back({rs, d});
    s_axi_araddr_i  <= ad;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
  endtask : rd
  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    s_axi_awaddr_i  <= ad;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o === 1'b1) ha = 1'b1;
      if (s_axi_wready_o === 1'b1) hw = 1'b1;
      if (ha) s_axi_awvalid_i <= 1'b0;
      if (hw) s_axi_wvalid_i <= 1'b0;
    end while (!(ha && hw));
    s_axi_bready_i <= 1'b1;
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
  endtask : wr
  task ins(input logic [IW-1:0] w);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    do @(posedge clk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : ins
  // Expected accumulator and status read back
  task chk();
    rd(ADDR_ACC, RESP_OKAY, {24'h0, a});
    rd(ADDR_STATUS, RESP_OKAY, {27'h0, st});
  endtask : chk
  // Subtract with borrow in, flags from both borrows
  task sub(input logic [7:0] x, input logic [7:0] y, input logic b);
    logic [8:0] f;
    logic [4:0] h;
    f = {1'b0, x} - {1'b0, y} - b;
    h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - b;
    a = f[7:0];
    st[2:0] = {f[7:0] == 8'h00, !h[4], !f[8]};
  endtask : sub

  ////////////////////////////////////////////////////////////////////////////
  // Result monitor: oldest note against each result
  always @(posedge clk_i)
  begin
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
      cmp(rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    if (file_req_o.we === 1'b1) cmp(fq.pop_front(), {10'h0, file_req_o.addr, file_req_o.wdata});
    if (stack_pop_o === 1'b1) cmp(pq.pop_front(), {19'h0, pc_o});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n_i, instr_valid_i, wake_i, s_axi_awvalid_i, s_axi_wvalid_i} = 5'h00;
    {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, instr_i, file_rdata_i} = 25'h0;
    {stack_top_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 63'h0;
    s_axi_wstrb_i = 4'hF;
    err_count = 0;
    check_count = 0;
    void'($urandom(32'hD5287034));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    a = ACC_RST;
    st = STATUS_RST;
    dir = 32'h00FFFFFF;
    chk();
    rd(ADDR_CTRL, RESP_OKAY, 32'h101);
    rd(8'h40, RESP_SLVERR, 32'h0);
    k = $urandom;
    ins(14'h3000 | k);
    a = k;
    chk();
    fq.push_back({10'h0, 16'h0020, a});
    ins(14'h01A0);
    ins(14'h0062);
    rd(ADDR_OPTION, RESP_OKAY, {24'h0, a});
    for (int i = 0; i < 4; i++)
    begin
      a = $urandom;
      ins(14'h3000 | a);
      ins(14'h0064 + i[13:0]);
      if (i > 0) dir[8*(i-1) +: 8] = a;
    end
    rd(ADDR_DIR, RESP_OKAY, dir);
    k = $urandom;
    ins(14'h3100 | k[6:0]);
    rd(ADDR_UPPER, RESP_OKAY, {25'h0, k[6:0]});
    k = $urandom;
    ins(14'h3C00 | k);
    sub(k, a, 1'b0);
    chk();
    k = $urandom;
    ins(14'h3A00 | k);
    a = a ^ k;
    st[2] = (a == 8'h00);
    chk();
    r = $urandom;
    file_rdata_i <= r;
    ins(14'h0D20);
    a = {r[6:0], st[0]};
    st[0] = r[7];
    chk();
    ins(14'h0C20);
    a = {st[0], r[7:1]};
    st[0] = r[0];
    chk();
    ins(14'h0220);
    sub(r, a, 1'b0);
    chk();
    ins(14'h3B20);
    sub(r, a, !st[0]);
    chk();
    ins(14'h0E20);
    a = {r[3:0], r[7:4]};
    chk();
    p = 16'hFFFF;
    wr(ADDR_PTR0, {16'h0, p});
    for (int i = 0; i < 4; i++)
    begin
      uc = i[1:0];
      s = uc[0] ? 16'hFFFF : 16'h0001;
      fq.push_back({10'h0, uc[1] ? p : p + s, a});
      ins(14'h0018 | uc);
      p = p + s;
    end
    rd(ADDR_PTR0, RESP_OKAY, {16'h0, p});
    fq.push_back({10'h0, p + 16'hFFE0, a});
    ins(14'h3F20);
    fq.push_back({10'h0, p, a});
    ins(14'h0180);
    rd(ADDR_PTR0, RESP_OKAY, {16'h0, p});
    chk();
    t = $urandom;
    stack_top_i <= t;
    pq.push_back({19'h0, t});
    ins(14'h0008);
    k = $urandom;
    pq.push_back({19'h0, t});
    ins(14'h3400 | k);
    a = k;
    chk();
    pq.push_back({19'h0, t});
    ins(14'h0009);
    rd(ADDR_CTRL, RESP_OKAY, 32'h181);
    ins(14'h0063);
    st[4:3] = 2'b10;
    chk();
    rd(ADDR_CTRL, RESP_OKAY, 32'h381);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    ins(14'h0001);
    rd(ADDR_CTRL, RESP_OKAY, 32'h001);
    a = ACC_RST;
    st = STATUS_RST;
    chk();
    results();
  end
endmodule : tb
